// ### rtl/chan_power_pkg.sv
// Package with offsets, field positions, reset values and widths of the channel power registers.
// Function
// - Channel enable at 0x76 resets to 0xCC; bits 7..4 enable input channels 1..4.
// - Channel enable bits 3..0 enable output channels 1..4; channels 1, 2 reset on.
// - Dynamic options bit 7: 0 refuses record changes while recording, 1 allows them.
// - Dynamic options bit 6: 0 covers record channels 1-2, 1 covers channels 1-4.
// - Dynamic options bit 5: 0 refuses playback changes while playing, 1 allows them.
// - Dynamic options bit 4: 0 covers playback channels 1-2, 1 covers channels 1-4.
// - Dynamic options bit 3 flags modulator clock differing from the PDM clock.
// - Dynamic options bits 2..0 are reserved, read zero; host writes only zero.
// - Power control bit 7: 0 powers all record channels down, 1 powers enabled ones.
// - Power control bit 6: 0 powers all playback channels down, 1 powers enabled ones.
// - Power control bit 5 powers the microphone supply; resets to zero.
// - Power control bit 3 enables the ultrasound activity detector.
// - Power control bit 2 enables the voice activity detector.
// - Power control bit 1 enables the second ultrasound activity detector.
// - Power control bits 4 and 0 are reserved, read zero; host writes only zero.
// - Status at 0x79 reports each channel's real power state, 1 meaning powered.
package chan_power_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned NUM_DYN_NARROW = 2;

  localparam logic [7:0] OFS_CHANNEL_ENABLE = 8'h76;
  localparam logic [7:0] OFS_DYNAMIC_POWER_OPTIONS = 8'h77;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h78;
  localparam logic [7:0] OFS_CHANNEL_POWER_STATUS = 8'h79;

  localparam logic [7:0] RST_CHANNEL_ENABLE = 8'hCC;
  localparam logic [7:0] RST_DYNAMIC_POWER_OPTIONS = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CHANNEL_POWER_STATUS = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Writable-bit masks; reserved positions are dropped on write and read as zero.
  localparam logic [7:0] MASK_DYNAMIC_POWER_OPTIONS = 8'hF8;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hEE;

  // Channel enable and status layout: channel 1 sits in the highest bit of each nibble.
  localparam int unsigned POS_INPUT_CHAN1 = 7;
  localparam int unsigned POS_OUTPUT_CHAN1 = 3;

  localparam int unsigned POS_RECORD_DYNAMIC_POWER = 7;
  localparam int unsigned POS_RECORD_DYNAMIC_RANGE = 6;
  localparam int unsigned POS_PLAYBACK_DYNAMIC_POWER = 5;
  localparam int unsigned POS_PLAYBACK_DYNAMIC_RANGE = 4;
  localparam int unsigned POS_SPLIT_MODULATOR_CLOCK = 3;

  localparam int unsigned POS_RECORD_POWER_ON = 7;
  localparam int unsigned POS_PLAYBACK_POWER_ON = 6;
  localparam int unsigned POS_MIC_SUPPLY_POWER_ON = 5;
  localparam int unsigned POS_ULTRASOUND_DETECT_ON = 3;
  localparam int unsigned POS_VOICE_DETECT_ON = 2;
  localparam int unsigned POS_ULTRASOUND_GATE_ON = 1;

endpackage

// ### rtl/chan_path_power.sv
// Power sequencing of the four channels of one audio path.
`timescale 1ns/1ps

module chan_path_power #(
  parameter int unsigned NUM_CHAN = chan_power_pkg::NUM_CHAN,
  parameter int unsigned NUM_NARROW = chan_power_pkg::NUM_DYN_NARROW
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_path_power_on,
  input wire logic [NUM_CHAN-1:0] i_chan_enable,
  input wire logic i_dynamic_power,
  input wire logic i_dynamic_range,
  output logic [NUM_CHAN-1:0] o_chan_power_q,
  output logic o_change_held_q
);

  logic [NUM_CHAN-1:0] power_d;
  logic any_on;

  assign any_on = |o_chan_power_q;

  // Index 0 is channel 1. With the path on and any channel running, only channels covered by the
  // dynamic option may follow their enable bit; others keep their state. Path off clears all.
  always_comb begin
    power_d = o_chan_power_q;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!i_path_power_on) begin
        power_d[i] = 1'b0;
      end else if (!any_on) begin
        power_d[i] = i_chan_enable[i];
      end else if (i_dynamic_power && (i < NUM_NARROW || i_dynamic_range)) begin
        power_d[i] = i_chan_enable[i];
      end else begin
        power_d[i] = o_chan_power_q[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_chan_power_q <= '0;
    end else begin
      o_chan_power_q <= power_d;
    end
  end

  // Flags a path whose requested channel set is being held back while it runs.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_change_held_q <= 1'b0;
    end else begin
      o_change_held_q <= i_path_power_on && (power_d != i_chan_enable);
    end
  end

endmodule

// ### rtl/chan_power_readback.sv
// Read multiplexer for the channel power register bank.
`timescale 1ns/1ps

module chan_power_readback (
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_channel_enable,
  input wire logic [7:0] i_dynamic_power_options,
  input wire logic [7:0] i_power_control,
  input wire logic [7:0] i_channel_power_status,
  output logic [7:0] o_rdata,
  output logic o_hit
);

  always_comb begin
    o_hit = 1'b1;
    case (i_addr)
      chan_power_pkg::OFS_CHANNEL_ENABLE: begin
        o_rdata = i_channel_enable;
      end
      chan_power_pkg::OFS_DYNAMIC_POWER_OPTIONS: begin
        o_rdata = i_dynamic_power_options & chan_power_pkg::MASK_DYNAMIC_POWER_OPTIONS;
      end
      chan_power_pkg::OFS_POWER_CONTROL: begin
        o_rdata = i_power_control & chan_power_pkg::MASK_POWER_CONTROL;
      end
      chan_power_pkg::OFS_CHANNEL_POWER_STATUS: begin
        o_rdata = i_channel_power_status;
      end
      default: begin
        o_rdata = chan_power_pkg::UNMAPPED_READ_VALUE;
        o_hit = 1'b0;
      end
    endcase
  end

endmodule

// ### rtl/channel_power_control_regs.sv
// Channel enable, dynamic power and path power register bank with channel sequencing.
`timescale 1ns/1ps

module channel_power_control_regs #(
  parameter int unsigned NUM_CHAN = chan_power_pkg::NUM_CHAN
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Register port from the control interface.
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [chan_power_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [chan_power_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [chan_power_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_reg_wr_ack,
  output logic o_reg_addr_miss,
  // Channel power controls, index 0 is channel 1.
  output logic [NUM_CHAN-1:0] o_input_chan_power,
  output logic [NUM_CHAN-1:0] o_output_chan_power,
  output logic o_record_change_held,
  output logic o_playback_change_held,
  output logic o_split_modulator_clock,
  output logic o_mic_supply_power_on,
  output logic o_ultrasound_detect_on,
  output logic o_voice_detect_on,
  output logic o_ultrasound_gate_on
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0] channel_enable_q;
  logic [7:0] dynamic_power_options_q;
  logic [7:0] power_control_q;
  logic [7:0] channel_power_status;
  logic wr_channel_enable;
  logic wr_dynamic_power_options;
  logic wr_power_control;

  // Address compare used by every write decode below.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Reverse a nibble so that channel 1, held in the high bit, lands on index 0.
  function automatic logic [3:0] chan_order(input logic [3:0] nib);
    chan_order = {nib[0], nib[1], nib[2], nib[3]};
  endfunction

  assign wr_channel_enable = i_reg_wr_en && hit(i_reg_addr, chan_power_pkg::OFS_CHANNEL_ENABLE);
  assign wr_dynamic_power_options =
    i_reg_wr_en && hit(i_reg_addr, chan_power_pkg::OFS_DYNAMIC_POWER_OPTIONS);
  assign wr_power_control = i_reg_wr_en && hit(i_reg_addr, chan_power_pkg::OFS_POWER_CONTROL);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      channel_enable_q <= chan_power_pkg::RST_CHANNEL_ENABLE;
    end else if (wr_channel_enable) begin
      channel_enable_q <= i_reg_wdata;
    end
  end

  // Reserved positions never store, so they read back as zero whatever is written.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dynamic_power_options_q <= chan_power_pkg::RST_DYNAMIC_POWER_OPTIONS;
    end else if (wr_dynamic_power_options) begin
      dynamic_power_options_q <= i_reg_wdata & chan_power_pkg::MASK_DYNAMIC_POWER_OPTIONS;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      power_control_q <= chan_power_pkg::RST_POWER_CONTROL;
    end else if (wr_power_control) begin
      power_control_q <= i_reg_wdata & chan_power_pkg::MASK_POWER_CONTROL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Path sequencing. The sequencers sample the registers one edge after the
  // write lands, so a change never acts on a half-written value.

  logic [NUM_CHAN-1:0] input_power_q;
  logic [NUM_CHAN-1:0] output_power_q;
  logic record_held_q;
  logic playback_held_q;

  chan_path_power #(
    .NUM_CHAN(NUM_CHAN),
    .NUM_NARROW(chan_power_pkg::NUM_DYN_NARROW)
  ) u_record_path (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_path_power_on(power_control_q[chan_power_pkg::POS_RECORD_POWER_ON]),
    .i_chan_enable(chan_order(channel_enable_q[7:4])),
    .i_dynamic_power(dynamic_power_options_q[chan_power_pkg::POS_RECORD_DYNAMIC_POWER]),
    .i_dynamic_range(dynamic_power_options_q[chan_power_pkg::POS_RECORD_DYNAMIC_RANGE]),
    .o_chan_power_q(input_power_q),
    .o_change_held_q(record_held_q)
  );

  chan_path_power #(
    .NUM_CHAN(NUM_CHAN),
    .NUM_NARROW(chan_power_pkg::NUM_DYN_NARROW)
  ) u_playback_path (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_path_power_on(power_control_q[chan_power_pkg::POS_PLAYBACK_POWER_ON]),
    .i_chan_enable(chan_order(channel_enable_q[3:0])),
    .i_dynamic_power(dynamic_power_options_q[chan_power_pkg::POS_PLAYBACK_DYNAMIC_POWER]),
    .i_dynamic_range(dynamic_power_options_q[chan_power_pkg::POS_PLAYBACK_DYNAMIC_RANGE]),
    .o_chan_power_q(output_power_q),
    .o_change_held_q(playback_held_q)
  );

  assign o_input_chan_power = input_power_q;
  assign o_output_chan_power = output_power_q;
  assign o_record_change_held = record_held_q;
  assign o_playback_change_held = playback_held_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Static controls straight from the register flops.

  assign o_split_modulator_clock =
    dynamic_power_options_q[chan_power_pkg::POS_SPLIT_MODULATOR_CLOCK];
  assign o_mic_supply_power_on = power_control_q[chan_power_pkg::POS_MIC_SUPPLY_POWER_ON];
  assign o_ultrasound_detect_on = power_control_q[chan_power_pkg::POS_ULTRASOUND_DETECT_ON];
  assign o_voice_detect_on = power_control_q[chan_power_pkg::POS_VOICE_DETECT_ON];
  assign o_ultrasound_gate_on = power_control_q[chan_power_pkg::POS_ULTRASOUND_GATE_ON];

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. Status reflects the sequencer flops, not the requested enables.

  logic [7:0] rdata_mux;
  logic rd_hit;

  assign channel_power_status = {chan_order(input_power_q), chan_order(output_power_q)};

  chan_power_readback u_readback (
    .i_addr(i_reg_addr),
    .i_channel_enable(channel_enable_q),
    .i_dynamic_power_options(dynamic_power_options_q),
    .i_power_control(power_control_q),
    .i_channel_power_status(channel_power_status),
    .o_rdata(rdata_mux),
    .o_hit(rd_hit)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reg_rdata <= chan_power_pkg::UNMAPPED_READ_VALUE;
    end else if (i_reg_rd_en) begin
      o_reg_rdata <= rdata_mux;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reg_rvalid <= 1'b0;
      o_reg_wr_ack <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd_en;
      o_reg_wr_ack <= i_reg_wr_en;
    end
  end

  // Misses cover unmapped addresses and writes to the read-only status register.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reg_addr_miss <= 1'b0;
    end else begin
      o_reg_addr_miss <= (i_reg_rd_en && !rd_hit) ||
        (i_reg_wr_en && !(wr_channel_enable || wr_dynamic_power_options || wr_power_control));
    end
  end

endmodule

// ### tb/chan_power_props.sv
// Concurrent checks on the ports of the channel power register bank.
`timescale 1ns/1ps
module chan_power_props #(
  parameter int unsigned NUM_CHAN = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_reg_wr_ack,
  input wire logic o_reg_addr_miss,
  input wire logic [NUM_CHAN-1:0] o_input_chan_power,
  input wire logic [NUM_CHAN-1:0] o_output_chan_power
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  logic hit;
  logic wr_pw;
  assign hit = i_reg_addr >= 8'h76 && i_reg_addr <= 8'h79;
  assign wr_pw = i_reg_wr_en && i_reg_addr == 8'h78;
  wr_ack_pulse_a: assert property (o_reg_wr_ack == $past(i_reg_wr_en))
    else $error("write ack not one cycle after strobe");
  rd_valid_pulse_a: assert property (i_reg_rd_en |=> o_reg_rvalid)
    else $error("read valid missing");
  rdata_hold_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (i_reg_rd_en && !hit |=>
    o_reg_addr_miss && o_reg_rdata == 8'h00)
    else $error("unmapped read not refused");
  status_write_a: assert property (i_reg_wr_en && i_reg_addr == 8'h79 |=> o_reg_addr_miss)
    else $error("status write not refused");
  no_false_miss_a: assert property (!(i_reg_rd_en && !hit) &&
    !(i_reg_wr_en && (!hit || i_reg_addr == 8'h79)) |=> !o_reg_addr_miss)
    else $error("miss on a mapped access");
  dyn_reserved_a: assert property (i_reg_rd_en && i_reg_addr == 8'h77 |=>
    o_reg_rdata[2:0] == 3'h0)
    else $error("reserved option bits read nonzero");
  pwr_reserved_a: assert property (i_reg_rd_en && i_reg_addr == 8'h78 |=>
    o_reg_rdata[4] == 1'h0 && o_reg_rdata[0] == 1'h0)
    else $error("reserved power bits read nonzero");
  record_off_a: assert property (wr_pw && !i_reg_wdata[7] |=> ##1 o_input_chan_power == '0)
    else $error("record channels not powered down");
  playback_off_a: assert property (wr_pw && !i_reg_wdata[6] |=> ##1 o_output_chan_power == '0)
    else $error("playback channels not powered down");
  cover property (wr_pw && i_reg_wdata[7]);
  cover property (i_reg_rd_en && !hit);
  cover property (o_input_chan_power[2]);
endmodule
bind channel_power_control_regs chan_power_props #(.NUM_CHAN(NUM_CHAN)) props_u (
  .i_sys_clk(i_sys_clk),
  .i_srst(i_srst),
  .i_reg_wr_en(i_reg_wr_en),
  .i_reg_rd_en(i_reg_rd_en),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid),
  .o_reg_wr_ack(o_reg_wr_ack),
  .o_reg_addr_miss(o_reg_addr_miss),
  .o_input_chan_power(o_input_chan_power),
  .o_output_chan_power(o_output_chan_power)
);

// ### tb/tb_top.sv
// Self-checking testbench for the channel power register bank.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr_en = 1'b0;
  logic i_reg_rd_en = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid, o_reg_wr_ack, o_reg_addr_miss;
  logic [3:0] o_input_chan_power, o_output_chan_power;
  logic o_record_change_held, o_playback_change_held, o_split_modulator_clock;
  logic o_mic_supply_power_on, o_ultrasound_detect_on, o_voice_detect_on, o_ultrasound_gate_on;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h180e247b;
  logic [7:0] d, v;
  logic [3:0] misc;
  logic [9:0] pst;
  logic [7:0] rst [4] = '{8'hCC, 8'h00, 8'h00, 8'h00};
  logic [7:0] sa [8] = '{8'h76, 8'h77, 8'h77, 8'h76, 8'h77, 8'h77, 8'h76, 8'h78};
  logic [7:0] sd [8] = '{8'hEC, 8'h80, 8'hC0, 8'hEE, 8'hE0, 8'hF0, 8'h2E, 8'h00};
  logic [9:0] se [8] = '{10'h233, 10'h233, 10'h073, 10'h173, 10'h173, 10'h077, 10'h047, 10'h000};
  assign misc = {o_mic_supply_power_on, o_ultrasound_detect_on, o_voice_detect_on,
    o_ultrasound_gate_on};
  assign pst = {o_record_change_held, o_playback_change_held, o_input_chan_power,
    o_output_chan_power};
  channel_power_control_regs dut_u (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_reg_wr_en(i_reg_wr_en),
    .i_reg_rd_en(i_reg_rd_en),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_reg_wr_ack(o_reg_wr_ack),
    .o_reg_addr_miss(o_reg_addr_miss),
    .o_input_chan_power(o_input_chan_power),
    .o_output_chan_power(o_output_chan_power),
    .o_record_change_held(o_record_change_held),
    .o_playback_change_held(o_playback_change_held),
    .o_split_modulator_clock(o_split_modulator_clock),
    .o_mic_supply_power_on(o_mic_supply_power_on),
    .o_ultrasound_detect_on(o_ultrasound_detect_on),
    .o_voice_detect_on(o_voice_detect_on),
    .o_ultrasound_gate_on(o_ultrasound_gate_on)
  );
  // Read-back value of a written byte: reserved positions always read as zero.
  function automatic logic [7:0] rd_exp(input logic [7:0] a, input logic [7:0] w);
    case (a)
      8'h77: rd_exp = w & 8'hF8;
      8'h78: rd_exp = w & 8'hEE;
      default: rd_exp = w;
    endcase
  endfunction
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic tick;
    @(posedge i_sys_clk) #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w, input logic m);
    tick;
    i_reg_wr_en = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = w;
    tick;
    i_reg_wr_en = 1'b0;
    `CHK({o_reg_wr_ack, o_reg_addr_miss}, {1'b1, m})
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    tick;
    i_reg_rd_en = 1'b1;
    i_reg_addr = a;
    tick;
    i_reg_rd_en = 1'b0;
    `CHK(o_reg_rvalid, 1'b1)
    q = o_reg_rdata;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // The whole sequence needs about 1700 ns; over ten times that means a hang.
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'h76 + i[7:0], d);
      `CHK(d, rst[i])
    end
    rd(8'h80, d);
    `CHK({o_reg_addr_miss, d}, 9'h100)
    wr(8'h80, 8'h5A, 1'b1);
    wr(8'h79, 8'hFF, 1'b1);
    rd(8'h79, d);
    `CHK(d, 8'h00)
    // Random bytes include reserved bits on purpose, to see them dropped.
    for (int i = 0; i < 30; i++) begin
      v = 8'($random(seed));
      wr(8'h76, v, 1'b0);
      rd(8'h76, d);
      `CHK(d, rd_exp(8'h76, v))
      v = 8'($random(seed));
      wr(8'h77, v, 1'b0);
      rd(8'h77, d);
      `CHK(d, rd_exp(8'h77, v))
      `CHK(o_split_modulator_clock, v[3])
      v = 8'($random(seed));
      wr(8'h78, v, 1'b0);
      rd(8'h78, d);
      `CHK(d, rd_exp(8'h78, v))
      `CHK(misc, {v[5], v[3:1]})
    end
    wr(8'h78, 8'h00, 1'b0);
    wr(8'h77, 8'h00, 1'b0);
    wr(8'h76, 8'hCC, 1'b0);
    wr(8'h78, 8'hC0, 1'b0);
    tick;
    `CHK({o_input_chan_power, o_output_chan_power}, 8'h33)
    rd(8'h79, d);
    `CHK(d, 8'hCC)
    for (int i = 0; i < 8; i++) begin
      wr(sa[i], sd[i], 1'b0);
      tick;
      `CHK(pst, se[i])
    end
    rd(8'h79, d);
    `CHK(d, 8'h00)
    wrap_up;
  end
endmodule
